// ### src/frontend_port_pkg.sv
// shared constants of the feedback front-end control port
package frontend_port_pkg;
  // ----------------------------------------------------------------
  // clock and widths
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 125;
  localparam int CLK_HZ = 125000000;
  localparam int ATTEN_WORD_W = 8;
  localparam int ATTEN_COUNT = 4;
  localparam int CONV_DATA_W = 12;
  localparam int CONV_FRAME_W = 16;
  localparam int CONV_ADDR_LSB = 12;
  localparam int CONV_ADDR_W = 3;
  localparam logic [11:0] CONV_RESET_CODE = 12'h000;
  localparam logic [ATTEN_WORD_W-1:0] ATTEN_RESET_WORD = 8'h00;
  // ----------------------------------------------------------------
  // converter channel addresses
  // ----------------------------------------------------------------
  localparam logic [2:0] CH_FAN = 3'h0;
  localparam logic [2:0] CH_BACKEND = 3'h4;
  localparam logic [2:0] CH_HORIZONTAL = 3'h5;
  localparam logic [2:0] CH_VERTICAL = 3'h6;
  localparam logic [2:0] CH_LONGITUDINAL = 3'h7;
  // ----------------------------------------------------------------
  // single-wire thermometer timing and commands
  // ----------------------------------------------------------------
  localparam int RESET_LOW_US = 480;
  localparam int PRESENCE_WAIT_US = 30;
  localparam int PRESENCE_LOW_US = 120;
  localparam int SLOT_SAMPLE_US = 30;
  localparam int READ_ZERO_US = 30;
  localparam int PRESENCE_WAIT_CYC = PRESENCE_WAIT_US * CLK_MHZ;
  localparam int SLOT_SAMPLE_CYC = SLOT_SAMPLE_US * CLK_MHZ;
  localparam int READ_ZERO_CYC = READ_ZERO_US * CLK_MHZ;
  localparam logic [7:0] CMD_READ_ID = 8'h33;
  localparam logic [7:0] CMD_READ_TEMP = 8'hBE;
  localparam int ID_BITS = 64;
  localparam int TEMP_BITS = 16;
  // ----------------------------------------------------------------
  // fan tachometer model
  // ----------------------------------------------------------------
  localparam int FAN_RPM_MAX = 4000;
  localparam int FAN_RPM_MIN = 1600;
  localparam int FAN_CODE_SPAN = 4096;
  localparam int RPM_PER_HZ = 30;
  localparam int TACH_ACC_W = 48;
  // toggles per second are rpm / (RPM_PER_HZ / 2); increment is rpm * code span
  localparam logic [47:0] TACH_MODULUS =
    48'(CLK_HZ) * 48'(RPM_PER_HZ / 2) * 48'(FAN_CODE_SPAN);
endpackage

// ### src/atten_channel.sv
// one attenuator: serial shift register, latch and read-back
`timescale 1ns/1ps
module atten_channel #(
  parameter int WORD_W = 8
) (
  input wire logic core_clk_in,
  input wire logic reset_in,
  input wire logic shift_pulse_in,
  input wire logic shift_bit_in,
  input wire logic latch_pulse_in,
  output logic [WORD_W-1:0] setting_out,
  output logic readback_out
);
  logic [WORD_W-1:0] shift_r;

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      shift_r <= '0;
    end else if (shift_pulse_in) begin
      shift_r <= {shift_r[WORD_W-2:0], shift_bit_in};
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      readback_out <= 1'b0;
    end else if (shift_pulse_in) begin
      readback_out <= shift_r[WORD_W-2];
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      setting_out <= frontend_port_pkg::ATTEN_RESET_WORD;
    end else if (latch_pulse_in) begin
      setting_out <= shift_r;
    end
  end

  a_readback_msb: assert property (@(posedge core_clk_in) disable iff (reset_in)
    shift_pulse_in |=> readback_out == $past(shift_r[WORD_W-2]))
    else $error("read-back does not follow shift register");
  a_latch_adopts: assert property (@(posedge core_clk_in) disable iff (reset_in)
    latch_pulse_in |=> setting_out == $past(shift_r))
    else $error("latched setting differs from shifted word");
  a_setting_holds: assert property (@(posedge core_clk_in) disable iff (reset_in)
    !latch_pulse_in |=> $stable(setting_out))
    else $error("setting changed without latch strobe");
endmodule // atten_channel

// ### src/fan_speed_pulse_out_gen.sv
// fan tachometer square wave whose rate falls as the fan code rises
`timescale 1ns/1ps
module fan_speed_pulse_out_gen #(
  parameter logic [47:0] MODULUS = frontend_port_pkg::TACH_MODULUS
) (
  input wire logic core_clk_in,
  input wire logic reset_in,
  input wire logic [11:0] fan_code_in,
  output logic tach_low_out
);
  localparam int AW = frontend_port_pkg::TACH_ACC_W;
  localparam logic [AW-1:0] INC_TOP =
    AW'(frontend_port_pkg::FAN_RPM_MAX) * AW'(frontend_port_pkg::FAN_CODE_SPAN);
  localparam logic [AW-1:0] INC_STEP =
    AW'(frontend_port_pkg::FAN_RPM_MAX - frontend_port_pkg::FAN_RPM_MIN);

  logic [AW-1:0] inc;
  logic [AW-1:0] acc_r;
  logic [AW-1:0] acc_nxt;

  // inverted control: code 0 gives the top speed, speed falls linearly
  assign inc = INC_TOP - INC_STEP * AW'(fan_code_in);
  assign acc_nxt = acc_r + inc;

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      acc_r <= '0;
      tach_low_out <= 1'b0;
    end else if (acc_nxt >= MODULUS) begin
      acc_r <= acc_nxt - MODULUS;
      tach_low_out <= ~tach_low_out;
    end else begin
      acc_r <= acc_nxt;
    end
  end

  a_inc_inverted: assert property (@(posedge core_clk_in) disable iff (reset_in)
    (fan_code_in == 12'h000) |-> inc == INC_TOP)
    else $error("code zero does not give maximum speed");
  a_wrap_toggles: assert property (@(posedge core_clk_in) disable iff (reset_in)
    (acc_nxt >= MODULUS) |=> tach_low_out != $past(tach_low_out))
    else $error("tachometer failed to toggle on wrap");
endmodule // fan_speed_pulse_out_gen

// ### src/frontend_control_port.sv
// rear-panel control port: attenuators, converter, thermometer, tachometer
//
// Overview of operation
// - one 8-bit word shifted on the shared clock and data lines enters all four attenuators.
// - a high pulse on one latch strobe makes only that attenuator adopt the shifted word.
// - each attenuator shows its shift register output on its own read-back pin.
// - an eight-channel 12-bit converter is loaded over its own clock, data and select inputs.
// - channel A sets fan speed, B to D are unused, E back-end phase, F G H front-end phases.
// - phase channels take every code from 0 to 4095.
// - the fan channel is inverted, code 0 giving the highest speed.
// - fan drive falls linearly with the code over a span of 4096.
// - after power-on all converter outputs are code 0, so the fan runs at full speed.
// - the thermometer gives out a unique serial number on the single-wire line.
// - the tachometer is an open-collector square wave, two periods per revolution.
// - the revision sense pin is grounded to mark the current interface.
`timescale 1ns/1ps
module frontend_control_port #(
  parameter int RESET_LOW_CYC = frontend_port_pkg::RESET_LOW_US * frontend_port_pkg::CLK_MHZ,
  parameter int PRESENCE_LOW_CYC =
    frontend_port_pkg::PRESENCE_LOW_US * frontend_port_pkg::CLK_MHZ,
  parameter logic [47:0] TACH_MODULUS = frontend_port_pkg::TACH_MODULUS,
  parameter logic [63:0] SERIAL_ID = 64'h0123_4567_89AB_CD28 // arbitrary value
) (
  input wire logic core_clk_in,
  input wire logic reset_in,
  input wire logic atten_shift_clock_in,
  input wire logic atten_shift_data_in,
  input wire logic longitudinal_atten_latch_in,
  input wire logic vertical_atten_latch_in,
  input wire logic horizontal_atten_latch_in,
  input wire logic backend_atten_latch_in,
  output logic longitudinal_atten_readback_out,
  output logic vertical_atten_readback_out,
  output logic horizontal_atten_readback_out,
  output logic backend_atten_readback_out,
  output logic [7:0] longitudinal_atten_setting_out,
  output logic [7:0] vertical_atten_setting_out,
  output logic [7:0] horizontal_atten_setting_out,
  output logic [7:0] backend_atten_setting_out,
  input wire logic converter_shift_clock_in,
  input wire logic converter_shift_data_in,
  input wire logic converter_select_n_in,
  output logic [11:0] fan_speed_code_out,
  output logic [11:0] backend_phase_code_out,
  output logic [11:0] horizontal_phase_code_out,
  output logic [11:0] vertical_phase_code_out,
  output logic [11:0] longitudinal_phase_code_out,
  input wire logic [15:0] temperature_in,
  input wire logic thermometer_line_in,
  output logic thermometer_line_out,
  output logic thermometer_line_oe_out,
  output logic fan_speed_pulse_out,
  output logic fan_speed_pulse_oe_out,
  output logic interface_revision_sense_out,
  output logic interface_revision_sense_oe_out
);
  localparam int AW = frontend_port_pkg::ATTEN_WORD_W;
  localparam int FW = frontend_port_pkg::CONV_FRAME_W;
  localparam int LCW = $clog2(RESET_LOW_CYC + 1);
  // slot counter must span the longest of the presence and 30 us slot timings
  localparam int SLOT_A = frontend_port_pkg::PRESENCE_WAIT_CYC > frontend_port_pkg::SLOT_SAMPLE_CYC ?
    frontend_port_pkg::PRESENCE_WAIT_CYC : frontend_port_pkg::SLOT_SAMPLE_CYC;
  localparam int SLOT_B = SLOT_A > frontend_port_pkg::READ_ZERO_CYC ?
    SLOT_A : frontend_port_pkg::READ_ZERO_CYC;
  localparam int SLOT_MAX = SLOT_B > PRESENCE_LOW_CYC ? SLOT_B : PRESENCE_LOW_CYC;
  localparam int SCW = $clog2(SLOT_MAX + 1);

  // ----------------------------------------------------------------
  // pin synchronisers and edge detection
  // ----------------------------------------------------------------
  localparam int P_ACLK = 0;
  localparam int P_ADAT = 1;
  localparam int P_LAT = 2;
  localparam int P_CCLK = 6;
  localparam int P_CDAT = 7;
  localparam int P_CSN = 8;
  localparam int P_THERM = 9;
  localparam int NPIN = 10;

  logic [NPIN-1:0] pins;
  logic [NPIN-1:0] sync1_r;
  logic [NPIN-1:0] sync2_r;
  logic [NPIN-1:0] prev_r;
  logic [NPIN-1:0] rise;
  logic [NPIN-1:0] fall;

  assign pins = {thermometer_line_in, converter_select_n_in, converter_shift_data_in,
                 converter_shift_clock_in, backend_atten_latch_in,
                 horizontal_atten_latch_in, vertical_atten_latch_in,
                 longitudinal_atten_latch_in, atten_shift_data_in, atten_shift_clock_in};

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      sync1_r <= '1;
      sync2_r <= '1;
      prev_r <= '1;
    end else begin
      sync1_r <= pins;
      sync2_r <= sync1_r;
      prev_r <= sync2_r;
    end
  end

  assign rise = sync2_r & ~prev_r;
  assign fall = ~sync2_r & prev_r;

  // ----------------------------------------------------------------
  // attenuators: longitudinal, vertical, horizontal, back end
  // ----------------------------------------------------------------
  logic [AW-1:0] setting [frontend_port_pkg::ATTEN_COUNT];
  logic [frontend_port_pkg::ATTEN_COUNT-1:0] readback;

  for (genvar i = 0; i < frontend_port_pkg::ATTEN_COUNT; i++) begin : g_atten
    atten_channel #(.WORD_W(AW)) u_atten (
      .core_clk_in(core_clk_in),
      .reset_in(reset_in),
      .shift_pulse_in(rise[P_ACLK]),
      .shift_bit_in(sync2_r[P_ADAT]),
      .latch_pulse_in(rise[P_LAT+i]),
      .setting_out(setting[i]),
      .readback_out(readback[i])
    );
  end

  assign longitudinal_atten_readback_out = readback[0];
  assign vertical_atten_readback_out = readback[1];
  assign horizontal_atten_readback_out = readback[2];
  assign backend_atten_readback_out = readback[3];
  assign longitudinal_atten_setting_out = setting[0];
  assign vertical_atten_setting_out = setting[1];
  assign horizontal_atten_setting_out = setting[2];
  assign backend_atten_setting_out = setting[3];

  a_atten_same_word: assert property (@(posedge core_clk_in) disable iff (reset_in)
    readback == '0 || readback == '1)
    else $error("attenuators hold different shifted words");

  // ----------------------------------------------------------------
  // converter: 16-bit frames taken on the falling clock edge under select
  // ----------------------------------------------------------------
  logic [FW-1:0] frame_r;
  logic [4:0] frame_cnt_r;
  logic frame_full;
  logic [2:0] frame_addr;
  logic [11:0] frame_data;

  assign frame_full = frame_cnt_r >= 5'(FW);
  assign frame_addr = frame_r[frontend_port_pkg::CONV_ADDR_LSB +: frontend_port_pkg::CONV_ADDR_W];
  assign frame_data = frame_r[frontend_port_pkg::CONV_DATA_W-1:0];

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      frame_r <= '0;
      frame_cnt_r <= '0;
    end else if (fall[P_CSN]) begin
      frame_cnt_r <= '0;
    end else if (!sync2_r[P_CSN] && fall[P_CCLK]) begin
      frame_r <= {frame_r[FW-2:0], sync2_r[P_CDAT]};
      if (!frame_full) begin
        frame_cnt_r <= frame_cnt_r + 5'h01;
      end
    end
  end

  // channels B to D carry no function and their writes are dropped
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      fan_speed_code_out <= frontend_port_pkg::CONV_RESET_CODE;
      backend_phase_code_out <= frontend_port_pkg::CONV_RESET_CODE;
      horizontal_phase_code_out <= frontend_port_pkg::CONV_RESET_CODE;
      vertical_phase_code_out <= frontend_port_pkg::CONV_RESET_CODE;
      longitudinal_phase_code_out <= frontend_port_pkg::CONV_RESET_CODE;
    end else if (rise[P_CSN] && frame_full) begin
      unique case (frame_addr)
        frontend_port_pkg::CH_FAN: fan_speed_code_out <= frame_data;
        frontend_port_pkg::CH_BACKEND: backend_phase_code_out <= frame_data;
        frontend_port_pkg::CH_HORIZONTAL: horizontal_phase_code_out <= frame_data;
        frontend_port_pkg::CH_VERTICAL: vertical_phase_code_out <= frame_data;
        frontend_port_pkg::CH_LONGITUDINAL: longitudinal_phase_code_out <= frame_data;
        default: ;
      endcase
    end
  end

  a_conv_reset_zero: assert property (@(posedge core_clk_in)
    $past(reset_in) |-> fan_speed_code_out == 12'h000 && backend_phase_code_out == 12'h000)
    else $error("converter outputs not zero after reset");
  a_fan_channel_a: assert property (@(posedge core_clk_in) disable iff (reset_in)
    rise[P_CSN] && frame_full && frame_addr == frontend_port_pkg::CH_FAN
    |=> fan_speed_code_out == $past(frame_data))
    else $error("channel A write missed fan code");
  a_phase_full_span: assert property (@(posedge core_clk_in) disable iff (reset_in)
    rise[P_CSN] && frame_full && frame_addr == frontend_port_pkg::CH_LONGITUDINAL
    |=> longitudinal_phase_code_out == $past(frame_data))
    else $error("phase code not taken unchanged");
  a_short_frame_drop: assert property (@(posedge core_clk_in) disable iff (reset_in)
    rise[P_CSN] && !frame_full |=> $stable(fan_speed_code_out))
    else $error("short converter frame changed an output");

  // ----------------------------------------------------------------
  // single-wire thermometer slave: presence, id read, temperature read
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    TH_IDLE = 3'b000,
    TH_PRES_WAIT = 3'b001,
    TH_PRES_LOW = 3'b011,
    TH_RX_CMD = 3'b010,
    TH_TX_BITS = 3'b110
  } therm_state_t;

  therm_state_t th_state_r;
  logic [LCW-1:0] low_cnt_r;
  logic [SCW-1:0] slot_cnt_r;
  logic slot_active_r;
  logic [7:0] cmd_r;
  logic [6:0] bit_cnt_r;
  logic [6:0] tx_len_r;
  logic [63:0] tx_r;
  logic bus_reset;

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      low_cnt_r <= '0;
    end else if (sync2_r[P_THERM]) begin
      low_cnt_r <= '0;
    end else if (low_cnt_r != LCW'(RESET_LOW_CYC)) begin
      low_cnt_r <= low_cnt_r + LCW'(1);
    end
  end

  assign bus_reset = rise[P_THERM] && low_cnt_r == LCW'(RESET_LOW_CYC);

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      th_state_r <= TH_IDLE;
      slot_cnt_r <= '0;
      slot_active_r <= 1'b0;
      cmd_r <= '0;
      bit_cnt_r <= '0;
      tx_len_r <= '0;
      tx_r <= '0;
      thermometer_line_oe_out <= 1'b0;
    end else if (bus_reset) begin
      th_state_r <= TH_PRES_WAIT;
      slot_cnt_r <= '0;
      slot_active_r <= 1'b0;
      thermometer_line_oe_out <= 1'b0;
    end else begin
      unique case (th_state_r)
        TH_IDLE: ;
        TH_PRES_WAIT: begin
          slot_cnt_r <= slot_cnt_r + SCW'(1);
          if (slot_cnt_r == SCW'(frontend_port_pkg::PRESENCE_WAIT_CYC - 1)) begin
            th_state_r <= TH_PRES_LOW;
            slot_cnt_r <= '0;
            thermometer_line_oe_out <= 1'b1;
          end
        end
        TH_PRES_LOW: begin
          slot_cnt_r <= slot_cnt_r + SCW'(1);
          if (slot_cnt_r == SCW'(PRESENCE_LOW_CYC - 1)) begin
            th_state_r <= TH_RX_CMD;
            slot_cnt_r <= '0;
            bit_cnt_r <= '0;
            thermometer_line_oe_out <= 1'b0;
          end
        end
        TH_RX_CMD: begin
          if (fall[P_THERM]) begin
            slot_active_r <= 1'b1;
            slot_cnt_r <= '0;
          end else if (slot_active_r) begin
            slot_cnt_r <= slot_cnt_r + SCW'(1);
            if (slot_cnt_r == SCW'(frontend_port_pkg::SLOT_SAMPLE_CYC - 1)) begin
              slot_active_r <= 1'b0;
              cmd_r <= {sync2_r[P_THERM], cmd_r[7:1]};
              bit_cnt_r <= bit_cnt_r + 7'h01;
              if (bit_cnt_r == 7'h07) begin
                bit_cnt_r <= '0;
                if ({sync2_r[P_THERM], cmd_r[7:1]} == frontend_port_pkg::CMD_READ_ID) begin
                  th_state_r <= TH_TX_BITS;
                  tx_r <= SERIAL_ID;
                  tx_len_r <= 7'(frontend_port_pkg::ID_BITS);
                end else if ({sync2_r[P_THERM], cmd_r[7:1]} ==
                             frontend_port_pkg::CMD_READ_TEMP) begin
                  th_state_r <= TH_TX_BITS;
                  tx_r <= {48'h0, temperature_in};
                  tx_len_r <= 7'(frontend_port_pkg::TEMP_BITS);
                end else begin
                  th_state_r <= TH_IDLE;
                end
              end
            end
          end
        end
        TH_TX_BITS: begin
          if (fall[P_THERM]) begin
            slot_active_r <= 1'b1;
            slot_cnt_r <= '0;
            thermometer_line_oe_out <= ~tx_r[0];
          end else if (slot_active_r) begin
            slot_cnt_r <= slot_cnt_r + SCW'(1);
            if (slot_cnt_r == SCW'(frontend_port_pkg::READ_ZERO_CYC - 1)) begin
              slot_active_r <= 1'b0;
              thermometer_line_oe_out <= 1'b0;
              tx_r <= {1'b0, tx_r[63:1]};
              bit_cnt_r <= bit_cnt_r + 7'h01;
              if (bit_cnt_r == tx_len_r - 7'h01) begin
                th_state_r <= TH_IDLE;
              end
            end
          end
        end
        default: th_state_r <= TH_IDLE;
      endcase
    end
  end

  a_id_loaded: assert property (@(posedge core_clk_in) disable iff (reset_in)
    th_state_r == TH_RX_CMD && $past(th_state_r) == TH_RX_CMD
    ##1 th_state_r == TH_TX_BITS && tx_len_r == 7'(frontend_port_pkg::ID_BITS)
    |-> tx_r == SERIAL_ID)
    else $error("serial number not loaded for id read");
  a_presence_after: assert property (@(posedge core_clk_in) disable iff (reset_in)
    bus_reset |=> th_state_r == TH_PRES_WAIT && !thermometer_line_oe_out)
    else $error("bus reset not answered by presence sequence");

  // ----------------------------------------------------------------
  // fan tachometer and revision sense
  // ----------------------------------------------------------------
  logic tach_low;

  fan_speed_pulse_out_gen #(.MODULUS(TACH_MODULUS)) u_tach (
    .core_clk_in(core_clk_in),
    .reset_in(reset_in),
    .fan_code_in(fan_speed_code_out),
    .tach_low_out(tach_low)
  );

  // open-collector outputs only ever pull low
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      thermometer_line_out <= 1'b0;
      fan_speed_pulse_out <= 1'b0;
      interface_revision_sense_out <= 1'b0;
      interface_revision_sense_oe_out <= 1'b1;
    end else begin
      thermometer_line_out <= 1'b0;
      fan_speed_pulse_out <= 1'b0;
      interface_revision_sense_out <= 1'b0;
      interface_revision_sense_oe_out <= 1'b1;
    end
  end

  assign fan_speed_pulse_oe_out = tach_low;

  a_sense_grounded: assert property (@(posedge core_clk_in) disable iff (reset_in)
    interface_revision_sense_oe_out && !interface_revision_sense_out)
    else $error("revision sense not grounded");
  a_tach_open_drain: assert property (@(posedge core_clk_in) disable iff (reset_in)
    !fan_speed_pulse_out)
    else $error("tachometer driven high");
endmodule // frontend_control_port

// ### test/port_controller_model.sv
// controller model that drives the attenuator, converter and thermometer pins
`timescale 1ns/1ps
module port_controller_model (
  input wire logic core_clk_in,
  output logic atten_clk_out,
  output logic atten_data_out,
  output logic [3:0] latch_out,
  output logic conv_clk_out,
  output logic conv_data_out,
  output logic conv_select_n_out,
  output logic thermo_pull_out
);
  initial begin
    {atten_clk_out, atten_data_out, latch_out, conv_clk_out, conv_data_out} = '0;
    conv_select_n_out = 1'b1;
    thermo_pull_out = 1'b0;
  end
  // half of a 128 ns link period, changed at the falling core edge
  task automatic half();
    repeat (8) @(negedge core_clk_in);
  endtask
  task automatic atten_shift(input logic [7:0] w);
    for (int i = 7; i >= 0; i--) begin
      atten_data_out = w[i];
      half();
      atten_clk_out = 1'b1;
      half();
      atten_clk_out = 1'b0;
    end
  endtask
  task automatic atten_latch(input int c);
    latch_out[c] = 1'b1;
    half();
    latch_out[c] = 1'b0;
    half();
  endtask
  // bus reset on the single-wire line: pull low well past the reset time, then release
  task automatic therm_reset();
    thermo_pull_out = 1'b1;
    repeat (500) @(negedge core_clk_in);
    thermo_pull_out = 1'b0;
  endtask
  task automatic conv_frame(input int n, input logic [15:0] f);
    conv_select_n_out = 1'b0;
    half();
    for (int i = n - 1; i >= 0; i--) begin
      conv_data_out = f[i];
      conv_clk_out = 1'b1;
      half();
      conv_clk_out = 1'b0;
      half();
    end
    conv_select_n_out = 1'b1;
    conv_data_out = ~conv_data_out;
    half();
  endtask
endmodule // port_controller_model

// ### test/frontend_control_port_bench.sv
// self-checking bench of the rear-panel control port
`timescale 1ns/1ps
module frontend_control_port_bench;
  logic core_clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic ac, ad, cc, cd, csn, tpull, t_o, t_oe, f_o, f_oe, r_o, r_oe;
  logic [3:0] le, rb;
  logic [7:0] st [4];
  logic [7:0] want [4] = '{default: 8'h00};
  logic [11:0] code [5];
  logic [11:0] cwant [5] = '{default: 12'h000};
  logic [2:0] addr [5];
  logic [15:0] temp = 16'h0000;
  logic [15:0] exp_q [$];
  int id_q [$];
  int n_fail = 0;
  int n_checks = 0;
  int n_tog = 0;
  logic f_prev = 1'b0;
  event chk_ev;
  always #4 core_clk_in = ~core_clk_in;
  // counts tachometer toggles, seen one edge late
  always @(posedge core_clk_in) begin
    if (f_oe !== f_prev) n_tog++;
    f_prev = f_oe;
  end
  port_controller_model port_controller_model_i (.core_clk_in(core_clk_in),
    .atten_clk_out(ac), .atten_data_out(ad), .latch_out(le), .conv_clk_out(cc),
    .conv_data_out(cd), .conv_select_n_out(csn), .thermo_pull_out(tpull));
  frontend_control_port #(.RESET_LOW_CYC(400), .PRESENCE_LOW_CYC(200),
    .TACH_MODULUS(48'h0000_0BEB_C200)) frontend_control_port_i (
    .core_clk_in(core_clk_in), .reset_in(reset_in), .atten_shift_clock_in(ac),
    .atten_shift_data_in(ad), .longitudinal_atten_latch_in(le[0]),
    .vertical_atten_latch_in(le[1]), .horizontal_atten_latch_in(le[2]),
    .backend_atten_latch_in(le[3]), .longitudinal_atten_readback_out(rb[0]),
    .vertical_atten_readback_out(rb[1]), .horizontal_atten_readback_out(rb[2]),
    .backend_atten_readback_out(rb[3]), .longitudinal_atten_setting_out(st[0]),
    .vertical_atten_setting_out(st[1]), .horizontal_atten_setting_out(st[2]),
    .backend_atten_setting_out(st[3]), .converter_shift_clock_in(cc),
    .converter_shift_data_in(cd), .converter_select_n_in(csn),
    .fan_speed_code_out(code[0]), .backend_phase_code_out(code[1]),
    .horizontal_phase_code_out(code[2]), .vertical_phase_code_out(code[3]),
    .longitudinal_phase_code_out(code[4]), .temperature_in(temp),
    .thermometer_line_in(~(t_oe | tpull)), .thermometer_line_out(t_o),
    .thermometer_line_oe_out(t_oe), .fan_speed_pulse_out(f_o),
    .fan_speed_pulse_oe_out(f_oe), .interface_revision_sense_out(r_o),
    .interface_revision_sense_oe_out(r_oe));
  function automatic logic [15:0] seen(input int id);
    if (id < 4) return {8'h00, st[id]};
    if (id < 9) return {4'h0, code[id-4]};
    if (id < 13) return {15'h0000, rb[id-9]};
    if (id == 13) return {15'h0000, r_oe};
    if (id == 14) return {13'h0000, t_o, f_o, r_o};
    if (id == 15) return {15'h0000, t_oe};
    return 16'(n_tog);
  endfunction
  task automatic note(input int id, input logic [15:0] e);
    id_q.push_back(id);
    exp_q.push_back(e);
  endtask
  task automatic flush();
    -> chk_ev;
    #1;
  endtask
  task automatic check(input int id, input logic [15:0] s, input logic [15:0] e);
    n_checks++;
    if (s !== e) begin
      n_fail++;
      $display("Error item%0d expected %h seen %h", id, e, s);
    end
  endtask
  // ----------------------------------------------------------------
  // watcher: compares each noted expectation with the outputs
  // ----------------------------------------------------------------
  always begin
    @chk_ev;
    while (id_q.size() > 0) begin
      automatic int id = id_q.pop_front();
      check(id, seen(id), exp_q.pop_front());
    end
  end
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #200us;
    n_fail++;
    tally_and_finish();
  end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [7:0] w;
    logic [11:0] v;
    void'($urandom(32'h5BE39DA8));
    addr = '{frontend_port_pkg::CH_FAN, frontend_port_pkg::CH_BACKEND,
      frontend_port_pkg::CH_HORIZONTAL, frontend_port_pkg::CH_VERTICAL,
      frontend_port_pkg::CH_LONGITUDINAL};
    temp = 16'($urandom());
    repeat (20) @(negedge core_clk_in);
    reset_in = 1'b0;
    repeat (1000) @(negedge core_clk_in);
    for (int i = 0; i < 9; i++) note(i, 16'h0000);
    note(13, 16'h0001);
    note(14, 16'h0000);
    note(15, 16'h0000);
    note(16, 16'(longint'(1000) * frontend_port_pkg::FAN_RPM_MAX *
      frontend_port_pkg::FAN_CODE_SPAN / 64'd200000000));
    flush();
    port_controller_model_i.therm_reset();
    repeat (3850) @(negedge core_clk_in);
    note(15, 16'h0001);
    flush();
    repeat (200) @(negedge core_clk_in);
    note(15, 16'h0000);
    flush();
    for (int c = 0; c < 4; c++) begin
      w = 8'($urandom());
      port_controller_model_i.atten_shift(w);
      repeat (6) @(negedge core_clk_in);
      for (int k = 0; k < 4; k++) note(9 + k, {15'h0000, w[7]});
      port_controller_model_i.atten_latch(c);
      repeat (6) @(negedge core_clk_in);
      want[c] = w;
      for (int k = 0; k < 4; k++) note(k, {8'h00, want[k]});
      flush();
    end
    for (int c = 0; c < 5; c++) begin
      v = (c == 4) ? 12'hFFF : 12'($urandom());
      port_controller_model_i.conv_frame(16, {1'b0, addr[c], v});
      port_controller_model_i.conv_frame(16, {1'b1, 3'h1 + 3'(c % 3), ~v});
      port_controller_model_i.conv_frame(15, {1'b0, addr[c], ~v});
      cwant[c] = v;
      for (int k = 0; k < 5; k++) note(4 + k, {4'h0, cwant[k]});
      flush();
    end
    tally_and_finish();
  end
endmodule // frontend_control_port_bench
